// ---- include/ric_pkg.sv ----
// ric_pkg: register map, field positions and reset values of the
// interrupt-enable unit of the real-time counter.
// assumes a 32-bit APB with byte addresses; each register is one word.

package ric_pkg;

	localparam int          RIC_ADDR_W       = 8;
	localparam int          RIC_DATA_W       = 32;
	localparam int          RIC_SRC_W        = 8;

	// register indices; byte address is four times the index
	localparam logic [7:0]  RIC_CTRL_IDX     = 8'h00;
	localparam logic [7:0]  RIC_ENSET_IDX    = 8'h05;
	localparam logic [7:0]  RIC_ENCLR_IDX    = 8'h06;
	localparam logic [7:0]  RIC_FLAG_IDX     = 8'h08;
	localparam logic [7:0]  RIC_STAT_IDX     = 8'h0A;
	localparam logic [7:0]  RIC_MASK_IDX     = 8'h0B;

	// bit positions shared by enable, flag, status and mask layouts, and the mode bit of the control word
	localparam int          RIC_OVF_BIT      = 7;
	localparam int          RIC_SYNC_BIT     = 6;
	localparam int          RIC_COMPARE_MATCH_SECOND_BIT     = 1;
	localparam int          RIC_COMPARE_MATCH_FIRST_BIT     = 0;
	localparam int          RIC_MODE_BIT     = 0;

	localparam logic [7:0]  RIC_VALID_SINGLE = 8'hC1;
	localparam logic [7:0]  RIC_VALID_16BIT  = 8'hC3;

	localparam logic        RIC_MODE_RST     = 1'b0;
	localparam logic [7:0]  RIC_ENABLE_RST   = 8'h00;
	localparam logic [7:0]  RIC_MASK_RST     = 8'h00;
	localparam logic [7:0]  RIC_STATUS_RST   = 8'h00;
	localparam logic [31:0] RIC_PRDATA_RST   = 32'h0000_0000;

	function automatic logic ric_hit(input logic [7:0] addr, input logic [7:0] idx);
		return addr == {idx[5:0], 2'b00};
	endfunction : ric_hit

	function automatic logic [7:0] ric_valid(input logic mode16);
		return mode16 ? RIC_VALID_16BIT : RIC_VALID_SINGLE;
	endfunction : ric_valid

endpackage : ric_pkg

// ---- include/ric_irq_if.sv ----
// ric_irq_if: events, read-clear and mask into the sticky status unit.
// assumes both ends run on the same pclk.
`timescale 1ns/1ns

interface ric_irq_if;
	logic [7:0] evt;
	logic [7:0] clr;
	logic [7:0] mask;
	logic [7:0] status;
	logic       irq;

	modport core (output evt, output clr, output mask, input status, input irq);
	modport unit (input evt, input clr, input mask, output status, output irq);
endinterface : ric_irq_if

// ---- hw/ric_irq_status.sv ----
// ric_irq_status: sticky interrupt status bits, read-clear, masked irq.
// assumes clr names only bits that software has already seen.
`timescale 1ns/1ns

module ric_irq_status
	import ric_pkg::*;
(
	input  wire logic pclk,
	input  wire logic presetn,
	ric_irq_if.unit   bus
);

	typedef struct packed {
		logic [7:0] status;
		logic       irq;
	} ric_stat_s;

	ric_stat_s stat_reg;
	ric_stat_s stat_next;

	always_comb begin
		stat_next        = stat_reg;
		// set wins over a clear in the same cycle
		stat_next.status = (stat_reg.status & ~bus.clr) | bus.evt;
		stat_next.irq    = |(stat_next.status & bus.mask);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stat_reg <= '{status: RIC_STATUS_RST, irq: 1'b0};
		end else begin
			stat_reg <= stat_next;
		end
	end

	assign bus.status = stat_reg.status;
	assign bus.irq    = stat_reg.irq;

	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_event_sticky: assert property ((bus.evt != 8'h00) |=> ((bus.status & $past(bus.evt)) == $past(bus.evt)))
		else $error("event did not set its status bit");
	a_irq_follows: assert property (##1 (bus.irq == |(bus.status & $past(bus.mask))))
		else $error("irq level disagrees with status and mask");

endmodule : ric_irq_status

// ---- hw/ric_irq_enable_clear.sv ----
// ric_irq_enable_clear: APB register block holding the interrupt enables
// of the real-time counter, with per-source requests and one irq line.
// assumes flags come synchronous to pclk from the counter logic.
//
// Behaviour
// - writing zero to an enable-clear bit leaves that enable unchanged
// - writing one to bit 7 clears the overflow enable
// - writing one to bit 6 clears the sync-done enable
// - writing one to bit 0 clears the first compare enable
// - overflow request follows the flag while enabled, stays low while disabled
// - sync-done request asserts when its flag sets while enabled
// - first compare request asserts when its flag sets while enabled
// - 16-bit mode: clear register at 0x06, reset 0x00, adds bit 1
`timescale 1ns/1ns

module ric_irq_enable_clear
	import ric_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        counter_overflow_flag,
	input  wire logic        sync_done_flag,
	input  wire logic        compare_match_first_flag,
	input  wire logic        compare_match_second_flag,
	output logic      [7:0]  irq_request,
	output logic             irq
);

	typedef struct packed {
		logic        mode;
		logic [7:0]  en;
		logic [7:0]  mask;
		logic [7:0]  req;
		logic [31:0] prdata;
	} ric_core_s;

	ric_core_s   core_reg;
	ric_core_s   core_next;

	logic [7:0]  flags;
	logic [7:0]  en_vis;
	logic        wr_any;
	logic        rd_setup;
	logic        rd_acc;
	logic        mapped;
	logic        wr_clr;
	logic        wr_set;
	logic        wr_ctrl;

	ric_irq_if   irq_bus ();

	assign flags    = {counter_overflow_flag, sync_done_flag, 4'h0,
	                   compare_match_second_flag, compare_match_first_flag};
	assign wr_any   = psel & penable & pwrite;
	assign rd_setup = psel & ~penable & ~pwrite;
	assign rd_acc   = psel & penable & ~pwrite;
	assign wr_clr   = wr_any & ric_hit(paddr, RIC_ENCLR_IDX);
	assign wr_set   = wr_any & ric_hit(paddr, RIC_ENSET_IDX);
	assign wr_ctrl  = wr_any & ric_hit(paddr, RIC_CTRL_IDX);
	// bit 1 is hidden and inert outside the 16-bit mode
	assign en_vis   = core_reg.en & ric_valid(core_reg.mode);

	assign mapped   = ric_hit(paddr, RIC_CTRL_IDX) | ric_hit(paddr, RIC_ENSET_IDX)
	                | ric_hit(paddr, RIC_ENCLR_IDX) | ric_hit(paddr, RIC_FLAG_IDX)
	                | ric_hit(paddr, RIC_STAT_IDX) | ric_hit(paddr, RIC_MASK_IDX);

	always_comb begin
		logic [31:0] rdata;
		rdata     = 32'h0000_0000;
		core_next = core_reg;

		if (wr_ctrl) begin
			core_next.mode = pwdata[RIC_MODE_BIT];
		end
		if (wr_set) begin
			core_next.en = core_reg.en | (pwdata[7:0] & ric_valid(core_reg.mode));
		end
		if (wr_clr) begin
			// ones clear, zeros leave the enable alone
			core_next.en = core_reg.en & ~pwdata[7:0];
		end
		if (wr_any && ric_hit(paddr, RIC_MASK_IDX)) begin
			core_next.mask = pwdata[7:0] & RIC_VALID_16BIT;
		end

		// request follows flag while enabled, including a same-cycle enable change
		core_next.req = core_next.en & flags & ric_valid(core_next.mode);

		// read data is latched in the setup phase so it is stable in access
		if (ric_hit(paddr, RIC_CTRL_IDX)) begin
			rdata[RIC_MODE_BIT] = core_reg.mode;
		end else if (ric_hit(paddr, RIC_ENSET_IDX) || ric_hit(paddr, RIC_ENCLR_IDX)) begin
			rdata[7:0] = en_vis;
		end else if (ric_hit(paddr, RIC_FLAG_IDX)) begin
			rdata[7:0] = flags & ric_valid(core_reg.mode);
		end else if (ric_hit(paddr, RIC_STAT_IDX)) begin
			rdata[7:0] = irq_bus.status;
		end else if (ric_hit(paddr, RIC_MASK_IDX)) begin
			rdata[7:0] = core_reg.mask;
		end
		if (rd_setup) begin
			core_next.prdata = rdata;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			core_reg <= '{mode:   RIC_MODE_RST,
			              en:     RIC_ENABLE_RST,
			              mask:   RIC_MASK_RST,
			              req:    RIC_ENABLE_RST,
			              prdata: RIC_PRDATA_RST};
		end else begin
			core_reg <= core_next;
		end
	end

	// events are rising requests; only the bits actually returned are cleared,
	// so an event landing between setup and access is not lost
	assign irq_bus.evt  = core_next.req & ~core_reg.req;
	assign irq_bus.clr  = (rd_acc && ric_hit(paddr, RIC_STAT_IDX)) ? core_reg.prdata[7:0] : 8'h00;
	assign irq_bus.mask = core_reg.mask;

	ric_irq_status u_status (
		.pclk    (pclk),
		.presetn (presetn),
		.bus     (irq_bus)
	);

	// zero-wait slave; writes to read-only words are ignored without error
	assign pready      = 1'b1;
	assign pslverr     = psel & penable & ~mapped;
	assign prdata      = core_reg.prdata;
	assign irq_request = core_reg.req;
	assign irq         = irq_bus.irq;

	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_clear_zero_keeps: assert property (
		wr_clr |=> ((core_reg.en & ~$past(pwdata[7:0])) == ($past(core_reg.en) & ~$past(pwdata[7:0]))))
		else $error("zero written to enable-clear changed an enable");

	a_ovf_clear: assert property (
		(wr_clr && pwdata[RIC_OVF_BIT]) |=> (!core_reg.en[RIC_OVF_BIT] && !irq_request[RIC_OVF_BIT]))
		else $error("overflow enable not cleared");

	a_sync_clear: assert property (
		(wr_clr && pwdata[RIC_SYNC_BIT]) |=> (!core_reg.en[RIC_SYNC_BIT] && !irq_request[RIC_SYNC_BIT]))
		else $error("sync-done enable not cleared");

	a_compare_match_first_clear: assert property (
		(wr_clr && pwdata[RIC_COMPARE_MATCH_FIRST_BIT]) |=> (!core_reg.en[RIC_COMPARE_MATCH_FIRST_BIT] && !irq_request[RIC_COMPARE_MATCH_FIRST_BIT]))
		else $error("first compare enable not cleared");

	a_ovf_request: assert property (
		(!wr_any && core_reg.en[RIC_OVF_BIT] && counter_overflow_flag) |=> irq_request[RIC_OVF_BIT])
		else $error("enabled overflow flag gave no request");

	a_ovf_blocked: assert property (
		(!wr_any && !core_reg.en[RIC_OVF_BIT]) |=> !irq_request[RIC_OVF_BIT])
		else $error("disabled overflow raised a request");

	a_sync_request: assert property (
		(!wr_any && core_reg.en[RIC_SYNC_BIT] && $rose(sync_done_flag))
		|=> (irq_request[RIC_SYNC_BIT] && irq_bus.status[RIC_SYNC_BIT]))
		else $error("sync-done flag set gave no request or status");

	a_compare_match_first_request: assert property (
		(!wr_any && core_reg.en[RIC_COMPARE_MATCH_FIRST_BIT] && compare_match_first_flag) |=> irq_request[RIC_COMPARE_MATCH_FIRST_BIT])
		else $error("enabled first compare flag gave no request");

	a_compare_match_second_mode: assert property (
		(!wr_any && core_reg.mode && core_reg.en[RIC_COMPARE_MATCH_SECOND_BIT] && compare_match_second_flag)
		|=> irq_request[RIC_COMPARE_MATCH_SECOND_BIT])
		else $error("second compare request missing in 16-bit mode");

	a_compare_match_second_hidden: assert property (
		(!wr_any && !core_reg.mode) |=> (!irq_request[RIC_COMPARE_MATCH_SECOND_BIT] && !en_vis[RIC_COMPARE_MATCH_SECOND_BIT]))
		else $error("second compare active outside 16-bit mode");

	a_compare_match_second_clear: assert property (
		(wr_clr && pwdata[RIC_COMPARE_MATCH_SECOND_BIT]) |=> !core_reg.en[RIC_COMPARE_MATCH_SECOND_BIT])
		else $error("second compare enable not cleared");

	a_enclr_read: assert property (
		(rd_setup && ric_hit(paddr, RIC_ENCLR_IDX))
		|=> ((prdata[7:0] == $past(en_vis)) && (prdata[31:8] == 24'h00_0000)))
		else $error("enable-clear read data wrong");

	// irq is taken from the updated status, so an event may raise it at once
	a_irq_masked: assert property (
		(irq_bus.status == 8'h00) |-> !irq)
		else $error("irq high with no status bit set");

	a_req_level: assert property (
		##1 (irq_request == (core_reg.en & $past(flags) & ric_valid(core_reg.mode))))
		else $error("request disagrees with enables and flags");

	a_unused_bits: assert property (
		(core_reg.en[5:2] == 4'h0) && (irq_request[5:2] == 4'h0))
		else $error("unused enable or request bit set");

	a_compare_match_second_set_blocked: assert property (
		(wr_set && !core_reg.mode)
		|=> (core_reg.en[RIC_COMPARE_MATCH_SECOND_BIT] == $past(core_reg.en[RIC_COMPARE_MATCH_SECOND_BIT])))
		else $error("second compare enabled outside 16-bit mode");

	a_set_enables: assert property (
		wr_set |=> (core_reg.en == ($past(core_reg.en)
		            | ($past(pwdata[7:0]) & ric_valid($past(core_reg.mode))))))
		else $error("enable-set write gave wrong enables");

	a_mode_write: assert property (
		wr_ctrl |=> ((core_reg.mode == $past(pwdata[RIC_MODE_BIT]))
		             && (core_reg.en == $past(core_reg.en))))
		else $error("control write gave wrong mode or touched enables");

	a_mask_write: assert property (
		(wr_any && ric_hit(paddr, RIC_MASK_IDX))
		|=> (core_reg.mask == ($past(pwdata[7:0]) & RIC_VALID_16BIT)))
		else $error("mask write gave wrong mask");

	a_ro_write_ignored: assert property (
		(wr_any && (ric_hit(paddr, RIC_FLAG_IDX) || ric_hit(paddr, RIC_STAT_IDX)))
		|=> ((core_reg.en == $past(core_reg.en))
		     && (core_reg.mask == $past(core_reg.mask))
		     && (core_reg.mode == $past(core_reg.mode))))
		else $error("write to a read-only word changed state");

	a_status_clear: assert property (
		(rd_acc && ric_hit(paddr, RIC_STAT_IDX) && (irq_bus.evt == 8'h00))
		|=> ((irq_bus.status & $past(core_reg.prdata[7:0])) == 8'h00))
		else $error("status bits returned by a read were not cleared");

	a_status_read: assert property (
		(rd_setup && ric_hit(paddr, RIC_STAT_IDX))
		|=> (prdata[7:0] == $past(irq_bus.status)))
		else $error("status read data wrong");

	a_enset_read: assert property (
		(rd_setup && ric_hit(paddr, RIC_ENSET_IDX))
		|=> (prdata[7:0] == $past(en_vis)))
		else $error("enable-set read data wrong");

	a_flag_read: assert property (
		(rd_setup && ric_hit(paddr, RIC_FLAG_IDX))
		|=> (prdata[7:0] == ($past(flags) & ric_valid($past(core_reg.mode)))))
		else $error("flag read data wrong");

	a_mask_read: assert property (
		(rd_setup && ric_hit(paddr, RIC_MASK_IDX))
		|=> (prdata == {24'h00_0000, $past(core_reg.mask)}))
		else $error("mask read data wrong");

	a_ctrl_read: assert property (
		(rd_setup && ric_hit(paddr, RIC_CTRL_IDX))
		|=> (prdata == {31'h0, $past(core_reg.mode)}))
		else $error("control read data wrong");

	a_unmapped_zero: assert property (
		(rd_setup && !mapped) |=> (prdata == 32'h0000_0000))
		else $error("unmapped read returned data");

	// software may sample prdata late; it must not move between reads
	a_prdata_holds: assert property (
		!rd_setup |=> $stable(prdata))
		else $error("read data changed outside a read setup");

	a_slverr_decode: assert property (
		(psel && penable) |-> (pslverr == !mapped))
		else $error("error response disagrees with the address map");

	c_clear_ovf:  cover property (wr_clr && pwdata[RIC_OVF_BIT] && core_reg.en[RIC_OVF_BIT]);
	c_read_enclr: cover property (rd_setup && ric_hit(paddr, RIC_ENCLR_IDX) ##1 rd_acc);
	c_irq_raised: cover property ($rose(irq));
	c_compare_match_second_req:   cover property (core_reg.mode && irq_request[RIC_COMPARE_MATCH_SECOND_BIT]);
	c_sync_req:   cover property (core_reg.en[RIC_SYNC_BIT] && $rose(sync_done_flag));

endmodule : ric_irq_enable_clear

// ---- sim/tb_ric_irq_enable_clear.sv ----
// tb_ric_irq_enable_clear: apb-driven bench for the enable-clear register.
// assumes zero-wait apb slave and level flags synchronous to pclk.
`timescale 1ns/1ns

`define CHK(nm, exp, got) begin total_checks++; if ((got) !== (exp)) begin failures++; \
	$display("CHECK FAILED %s expected %0h seen %0h", nm, exp, got); end end

module tb_ric_irq_enable_clear;
	import ric_pkg::*;

	localparam logic [7:0] A_CTL = {RIC_CTRL_IDX[5:0], 2'b00};
	localparam logic [7:0] A_SET = {RIC_ENSET_IDX[5:0], 2'b00};
	localparam logic [7:0] A_CLR = {RIC_ENCLR_IDX[5:0], 2'b00};
	localparam logic [7:0] A_FLG = {RIC_FLAG_IDX[5:0], 2'b00};
	localparam logic [7:0] A_STA = {RIC_STAT_IDX[5:0], 2'b00};
	localparam logic [7:0] A_MSK = {RIC_MASK_IDX[5:0], 2'b00};

	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
	logic [7:0]  paddr, irq_request, exp_en;
	logic [31:0] pwdata, prdata, rd_val;
	logic [3:0]  flags;
	logic        err;
	int          failures, total_checks;
	int          bits[4] = '{7, 6, 0, 1};

	ric_irq_enable_clear dut_u (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr),
		.counter_overflow_flag(flags[3]), .sync_done_flag(flags[2]),
		.compare_match_second_flag(flags[1]), .compare_match_first_flag(flags[0]),
		.irq_request(irq_request), .irq(irq)
	);

	initial begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end

	task automatic tally_and_finish;
		if (failures == 0 && total_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : tally_and_finish

	// request held until the edge that samples pready high
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1 && n < 50) begin
			n++;
			@(posedge pclk);
		end
		if (n >= 50) begin
			failures++;
			tally_and_finish();
		end
		rd_val = prdata;
		err    = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string nm);
		apb(1'b0, a, 32'h0000_0000);
		`CHK(nm, {24'h00_0000, exp}, rd_val)
	endtask : rd

	// outputs lag their causes by a registered stage
	task automatic settle;
		repeat (2) @(posedge pclk);
		@(negedge pclk);
	endtask : settle

	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		flags = 4'h0;
		failures = 0;
		total_checks = 0;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		rd(A_CLR, RIC_ENABLE_RST, "clr_reset");
		`CHK("pready", 1'b1, pready)
		apb(1'b1, A_CTL, 32'h0000_0001);
		rd(A_CTL, 8'h01, "ctrl_mode");
		flags <= 4'hF;
		apb(1'b1, A_SET, 32'h0000_00C3);
		rd(A_CLR, 8'hC3, "clr_read_enables");
		settle();
		`CHK("req_all", 8'hC3, irq_request)
		rd(A_FLG, 8'hC3, "flag_raw");
		apb(1'b1, A_CLR, 32'hFFFF_FF3C);
		rd(A_CLR, 8'hC3, "clr_zeros_kept");
		exp_en = 8'hC3;
		foreach (bits[i]) begin
			exp_en[bits[i]] = 1'b0;
			apb(1'b1, A_CLR, 32'h1 << bits[i]);
			rd(A_CLR, exp_en, "clr_one_bit");
			settle();
			`CHK("req_after_clr", exp_en, irq_request)
		end
		// sticky status, mask and read-clear
		flags <= 4'h0;
		// bits from the first enable are still sticky; drain them before idle
		rd(A_STA, 8'hC3, "status_sticky");
		apb(1'b1, A_MSK, 32'h0000_0080);
		rd(A_MSK, 8'h80, "mask_read");
		apb(1'b1, A_SET, 32'h0000_0081);
		settle();
		`CHK("irq_idle", 1'b0, irq)
		flags <= 4'h9;
		settle();
		`CHK("irq_ovf", 1'b1, irq)
		flags <= 4'h0;
		rd(A_STA, 8'h81, "status_events");
		settle();
		`CHK("irq_cleared", 1'b0, irq)
		flags <= 4'h1;
		settle();
		`CHK("irq_masked", 1'b0, irq)
		rd(A_STA, 8'h01, "status_masked");
		rd(A_STA, 8'h00, "status_empty");
		flags <= 4'h0;
		apb(1'b1, A_SET, 32'h0000_0040);
		flags <= 4'h4;
		settle();
		`CHK("req_sync", 8'h40, irq_request)
		rd(A_STA, 8'h40, "status_sync");
		apb(1'b1, A_CLR, 32'h0000_0040);
		// single-compare mode hides bit 1
		apb(1'b1, A_CTL, 32'h0000_0000);
		apb(1'b1, A_SET, 32'h0000_0002);
		flags <= 4'h2;
		rd(A_CLR, 8'h81, "clr_single_mode");
		settle();
		`CHK("req_single_mode", 8'h00, irq_request)
		apb(1'b0, 8'h3C, 32'h0000_0000);
		`CHK("unmapped_err", 1'b1, err)
		`CHK("unmapped_data", 32'h0000_0000, rd_val)
		apb(1'b1, A_FLG, 32'h0000_00FF);
		`CHK("flag_write_err", 1'b0, err)
		tally_and_finish();
	end
endmodule : tb_ric_irq_enable_clear
